// file: rtl/ppi_pkg.sv
package ppi_pkg;

  localparam int PPI_STATES      = 256;
  localparam int PPI_STATE_W     = 8;
  localparam int PPI_DATA_W      = 32;
  localparam int PPI_CTRL_W      = 16;
  localparam int PPI_WM_BYTES    = 8192;
  localparam int PPI_WM_WORDS    = PPI_WM_BYTES / 4;
  localparam int PPI_WM_AW       = 11;
  localparam int PPI_ENTRY_AW    = 3;
  localparam int PPI_FIFO_DEPTH  = 8;
  localparam int PPI_BUF_W       = 5;
  localparam int PPI_SER_CW      = 3;
  localparam int PPI_SER_W       = 8;

  // Clock figures: core clock and the interface ceiling, in MHz
  localparam int PPI_CLK_MHZ     = 25;
  localparam int PPI_IF_MAX_MHZ  = 100;
  localparam int PPI_MASTER_DIV  = 2;
  localparam int PPI_IF_MHZ_X2   = (2 * PPI_CLK_MHZ) / PPI_MASTER_DIV;

  localparam logic [1:0] PPI_BUS8   = 2'h0;
  localparam logic [1:0] PPI_BUS16  = 2'h1;
  localparam logic [1:0] PPI_BUS32  = 2'h2;
  localparam logic [1:0] PPI_SERIAL = 2'h3;

  localparam logic [PPI_STATE_W-1:0] PPI_INIT_STATE = 8'h00;
  localparam logic [PPI_CTRL_W-1:0]  PPI_CTRL_ALL   = 16'hFFFF;
  localparam logic [PPI_CTRL_W-1:0]  PPI_CTRL_32    = 16'h3FFF;
  localparam logic [PPI_SER_CW-1:0]  PPI_SER_LAST   = 3'h7;

  // Word slots inside one 8-word state entry
  localparam logic [PPI_ENTRY_AW-1:0] PPI_W_DRIVE = 3'h0;
  localparam logic [PPI_ENTRY_AW-1:0] PPI_W_COND  = 3'h1;
  localparam logic [PPI_ENTRY_AW-1:0] PPI_W_NEXT  = 3'h2;
  localparam logic [PPI_ENTRY_AW-1:0] PPI_W_FLAG  = 3'h3;

  // Bit positions in the NEXT word
  localparam int PPI_B_TRUE    = 0;
  localparam int PPI_B_FALSE   = 8;
  localparam int PPI_B_CAPTURE = 16;
  localparam int PPI_B_SEND    = 17;
  localparam int PPI_B_DATA_OE = 18;
  localparam int PPI_B_BUF     = 19;

  typedef struct packed {
    logic [PPI_CTRL_W-1:0]  ctrlOe;
    logic [PPI_CTRL_W-1:0]  ctrlLvl;
    logic [PPI_CTRL_W-1:0]  condMatch;
    logic [PPI_CTRL_W-1:0]  condMask;
    logic [PPI_CTRL_W-1:0]  flagPins;
    logic [PPI_STATE_W-1:0] nextTrue;
    logic [PPI_STATE_W-1:0] nextFalse;
    logic                   capture;
    logic                   send;
    logic                   dataOe;
    logic                   bufLatch;
  } ppi_entry_t;

  typedef struct packed {
    logic [PPI_CTRL_W-1:0]  ctrlSyncA;
    logic [PPI_CTRL_W-1:0]  ctrlSyncB;
    logic [PPI_DATA_W-1:0]  dataSyncA;
    logic [PPI_DATA_W-1:0]  dataSyncB;
    logic                   enabled;
    logic [PPI_STATE_W-1:0] state;
    logic [PPI_CTRL_W-1:0]  ctrlLvl;
    logic [PPI_CTRL_W-1:0]  ctrlOe;
    logic [PPI_DATA_W-1:0]  dataOut;
    logic [PPI_DATA_W-1:0]  dataOe;
    logic                   clkOut;
    logic                   clkOe;
    logic [PPI_BUF_W-1:0]   bufIndex;
    logic [PPI_SER_W-1:0]   serShift;
    logic [PPI_SER_CW-1:0]  serCount;
    logic                   txTake;
  } ppi_core_t;

  localparam ppi_core_t PPI_CORE_RST = '0;

  function automatic logic [PPI_DATA_W-1:0] ppi_width_mask(input logic [1:0] w);
    logic [PPI_DATA_W-1:0] m;
    m = 32'h00000001;
    unique case (w)
      PPI_BUS8:   m = 32'h000000FF;
      PPI_BUS16:  m = 32'h0000FFFF;
      PPI_BUS32:  m = 32'hFFFFFFFF;
      PPI_SERIAL: m = 32'h00000001;
    endcase
    return m;
  endfunction : ppi_width_mask

endpackage : ppi_pkg

// file: rtl/ppi_top.sv
// Notes on behaviour
// - A mode input makes the block either master, driving the interface clock, or slave.
// - The sequencer has 256 states, all defined by loaded descriptor contents.
// - The data bus is used 8, 16 or 32 bits wide as selected.
// - The interface runs at most at 100 MHz; here the master clock is half the core clock.
// - In 32-bit mode only 14 control pins can be driven, the top two stay released.
// - In 16-bit and 8-bit mode all 16 control pins are usable.
// - Every control pin has its own enable per state, so it may be input, output or both.
// - The next state is chosen by comparing the synchronised control inputs with a mask.
// - Control pin levels are loaded only when a transition is taken.
// - The behaviour is read from a dedicated 8 kB waveform memory of 2048 words.
// - A serial mode shifts data pin 0 in and delivers a byte every eight captures.
// - Captured data carries a buffer index, 2 bits wide, or 5 bits when all buffers are on.
// - Any control pin may show, instead of a fixed level, the one of four buffer status flags picked by its pin number modulo four.
`timescale 1ns/10ps
`default_nettype none

module ppi_fifo
#(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
)
(
  input  wire logic             clock,
  input  wire logic             arst_n,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] wrPtr;
    logic [AW:0] rdPtr;
    logic        hasData;
    logic        noRoom;
  } ppi_fifo_t;

  ppi_fifo_t        fifo_reg;
  ppi_fifo_t        fifo_next;
  logic [WIDTH-1:0] store [DEPTH];
  logic             full;
  logic             empty;

  assign full     = fifo_reg.noRoom;
  assign empty    = !fifo_reg.hasData;
  assign inReady  = !full;
  assign outValid = fifo_reg.hasData;
  assign outData  = store[fifo_reg.rdPtr[AW-1:0]];

  always_comb
  begin
    fifo_next = fifo_reg;
    if (inValid && !full)
    begin
      fifo_next.wrPtr = fifo_reg.wrPtr + 1'b1;
    end
    if (outReady && !empty)
    begin
      fifo_next.rdPtr = fifo_reg.rdPtr + 1'b1;
    end
    fifo_next.hasData = (fifo_next.wrPtr != fifo_next.rdPtr);
    fifo_next.noRoom  = (fifo_next.wrPtr[AW] != fifo_next.rdPtr[AW]) &&
                        (fifo_next.wrPtr[AW-1:0] == fifo_next.rdPtr[AW-1:0]);
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fifo_reg <= '0;
    end
    else
    begin
      fifo_reg <= fifo_next;
    end
  end

  always_ff @(posedge clock)
  begin
    if (inValid && !full)
    begin
      store[fifo_reg.wrPtr[AW-1:0]] <= inData;
    end
  end

endmodule : ppi_fifo

module ppi_top
  import ppi_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  arst_n,
  input  wire logic                  enable,
  input  wire logic                  isMaster,
  input  wire logic [1:0]            busWidth,
  input  wire logic                  allBuffers,
  input  wire logic                  wmWrite,
  input  wire logic [PPI_WM_AW-1:0]  wmAddr,
  input  wire logic [PPI_DATA_W-1:0] wmData,
  input  wire logic [PPI_CTRL_W-1:0] ctrlPinIn,
  output logic      [PPI_CTRL_W-1:0] ctrlPinOut,
  output logic      [PPI_CTRL_W-1:0] ctrlPinOe,
  input  wire logic [PPI_DATA_W-1:0] dataPinIn,
  output logic      [PPI_DATA_W-1:0] dataPinOut,
  output logic      [PPI_DATA_W-1:0] dataPinOe,
  output logic                       clkPinOut,
  output logic                       clkPinOe,
  input  wire logic                  txValid,
  input  wire logic [PPI_DATA_W-1:0] txData,
  output logic                       txReady,
  output logic                       rxValid,
  input  wire logic                  rxReady,
  output logic      [PPI_DATA_W+PPI_BUF_W-1:0] rxData,
  output logic      [PPI_STATE_W-1:0]          stateNow
);

  ppi_core_t              core_reg;
  ppi_core_t              core_next;
  ppi_entry_t             entry;
  logic [PPI_DATA_W-1:0]  wave [PPI_WM_WORDS];
  logic [PPI_DATA_W-1:0]  wDrive;
  logic [PPI_DATA_W-1:0]  wCond;
  logic [PPI_DATA_W-1:0]  wNext;
  logic [PPI_DATA_W-1:0]  wFlag;
  logic [PPI_CTRL_W-1:0]  usable;
  logic [PPI_CTRL_W-1:0]  flagSpread;
  logic [PPI_CTRL_W-1:0]  levelNext;
  logic [3:0]             flagVec;
  logic [PPI_DATA_W-1:0]  widthMask;
  logic [PPI_SER_W-1:0]   shiftNext;
  logic                   condHit;
  logic                   step;
  logic                   stall;
  logic                   go;
  logic                   pushValid;
  logic                   pushReady;
  logic [PPI_DATA_W+PPI_BUF_W-1:0] pushData;

  // Entry fetch for the current state
  assign wDrive = wave[{core_reg.state, PPI_W_DRIVE}];
  assign wCond  = wave[{core_reg.state, PPI_W_COND}];
  assign wNext  = wave[{core_reg.state, PPI_W_NEXT}];
  assign wFlag  = wave[{core_reg.state, PPI_W_FLAG}];

  always_comb
  begin
    entry           = '0;
    entry.ctrlLvl   = wDrive[15:0];
    entry.ctrlOe    = wDrive[31:16];
    entry.condMask  = wCond[15:0];
    entry.condMatch = wCond[31:16];
    entry.flagPins  = wFlag[15:0];
    entry.nextTrue  = wNext[PPI_B_TRUE +: PPI_STATE_W];
    entry.nextFalse = wNext[PPI_B_FALSE +: PPI_STATE_W];
    entry.capture   = wNext[PPI_B_CAPTURE];
    entry.send      = wNext[PPI_B_SEND];
    entry.dataOe    = wNext[PPI_B_DATA_OE];
    entry.bufLatch  = wNext[PPI_B_BUF];
  end

  assign usable     = (busWidth == PPI_BUS32) ? PPI_CTRL_32 : PPI_CTRL_ALL;
  assign flagVec    = {!txValid, txValid, !pushReady, rxValid};
  assign flagSpread = {4{flagVec}};
  assign levelNext  = (entry.ctrlLvl & ~entry.flagPins) | (flagSpread & entry.flagPins);
  assign widthMask  = ppi_width_mask(busWidth);
  assign condHit    = ((core_reg.ctrlSyncB ^ entry.condMatch) & entry.condMask) == '0;
  assign step       = !isMaster || core_reg.clkOut;
  assign stall      = (entry.capture && !pushReady) || (entry.send && !txValid);
  assign go         = core_reg.enabled && enable && step && !stall;
  assign shiftNext  = {core_reg.serShift[PPI_SER_W-2:0], core_reg.dataSyncB[0]};

  // Capture path toward the internal buffers
  always_comb
  begin
    pushValid = 1'b0;
    pushData  = {core_reg.bufIndex, core_reg.dataSyncB & widthMask};
    if (go && entry.capture)
    begin
      if (busWidth == PPI_SERIAL)
      begin
        pushValid = (core_reg.serCount == PPI_SER_LAST);
        pushData  = {core_reg.bufIndex, {(PPI_DATA_W-PPI_SER_W){1'b0}}, shiftNext};
      end
      else
      begin
        pushValid = 1'b1;
      end
    end
  end

  always_comb
  begin
    core_next           = core_reg;
    core_next.ctrlSyncA = ctrlPinIn;
    core_next.ctrlSyncB = core_reg.ctrlSyncA;
    core_next.dataSyncA = dataPinIn;
    core_next.dataSyncB = core_reg.dataSyncA;
    core_next.txTake    = 1'b0;
    if (!enable)
    begin
      core_next.enabled  = 1'b0;
      core_next.state    = PPI_INIT_STATE;
      core_next.ctrlOe   = '0;
      core_next.dataOe   = '0;
      core_next.clkOe    = 1'b0;
      core_next.clkOut   = 1'b0;
      core_next.serCount = '0;
    end
    else
    begin
      core_next.enabled = 1'b1;
      core_next.clkOe   = isMaster;
      core_next.clkOut  = isMaster && !core_reg.clkOut;
      if (go)
      begin
        core_next.state   = condHit ? entry.nextTrue : entry.nextFalse;
        core_next.ctrlLvl = levelNext;
        core_next.ctrlOe  = entry.ctrlOe;
        core_next.dataOe  = {PPI_DATA_W{entry.dataOe}};
        if (entry.send)
        begin
          core_next.dataOut = txData;
          core_next.txTake  = 1'b1;
        end
        if (entry.capture && busWidth == PPI_SERIAL)
        begin
          core_next.serShift = shiftNext;
          core_next.serCount = core_reg.serCount + 1'b1;
        end
        if (entry.bufLatch)
        begin
          core_next.bufIndex = allBuffers ? core_reg.ctrlSyncB[PPI_BUF_W-1:0]
                                          : {3'h0, core_reg.ctrlSyncB[1:0]};
        end
      end
    end
    core_next.ctrlOe = core_next.ctrlOe & usable;
    core_next.dataOe = core_next.dataOe & ppi_width_mask(busWidth);
    core_next.dataOut = core_next.dataOut & ppi_width_mask(busWidth);
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      core_reg <= PPI_CORE_RST;
    end
    else
    begin
      core_reg <= core_next;
    end
  end

  // Descriptor load, refused while running
  always_ff @(posedge clock)
  begin
    if (wmWrite && !enable && !core_reg.enabled)
    begin
      wave[wmAddr] <= wmData;
    end
  end

  ppi_fifo
  #(
    .WIDTH (PPI_DATA_W + PPI_BUF_W),
    .DEPTH (PPI_FIFO_DEPTH)
  )
  rxFifo
  (
    .clock    (clock),
    .arst_n   (arst_n),
    .inValid  (pushValid),
    .inReady  (pushReady),
    .inData   (pushData),
    .outValid (rxValid),
    .outReady (rxReady),
    .outData  (rxData)
  );

  assign ctrlPinOut = core_reg.ctrlLvl;
  assign ctrlPinOe  = core_reg.ctrlOe;
  assign dataPinOut = core_reg.dataOut;
  assign dataPinOe  = core_reg.dataOe;
  assign clkPinOut  = core_reg.clkOut;
  assign clkPinOe   = core_reg.clkOe;
  assign txReady    = core_reg.txTake;
  assign stateNow   = core_reg.state;

  chk_idle_state: assert property (
    @(posedge clock) disable iff (!arst_n)
    !enable |=> (stateNow == PPI_INIT_STATE) && (ctrlPinOe == '0))
    else $error("state or drive not idle after disable");

  chk_top_pins_free: assert property (
    @(posedge clock) disable iff (!arst_n)
    (busWidth == PPI_BUS32) |=> (ctrlPinOe[15:14] == 2'b00))
    else $error("upper control pins driven in 32-bit mode");

  chk_wide_pin_use: assert property (
    @(posedge clock) disable iff (!arst_n)
    (go && busWidth != PPI_BUS32 && entry.ctrlOe[15] && $stable(busWidth))
      |=> ctrlPinOe[15])
    else $error("pin 15 not driven in narrow mode");

  chk_next_taken: assert property (
    @(posedge clock) disable iff (!arst_n)
    go |=> stateNow == ($past(condHit) ? $past(entry.nextTrue) : $past(entry.nextFalse)))
    else $error("wrong next state");

  chk_stall_hold: assert property (
    @(posedge clock) disable iff (!arst_n)
    (core_reg.enabled && enable && !go) |=> $stable(stateNow))
    else $error("state moved without a transition");

  chk_level_trans: assert property (
    @(posedge clock) disable iff (!arst_n)
    go |=> ctrlPinOut == $past(levelNext))
    else $error("pin levels not loaded on transition");

  chk_flag_pin: assert property (
    @(posedge clock) disable iff (!arst_n)
    (go && entry.flagPins[9]) |=> ctrlPinOut[9] == $past(flagVec[1]))
    else $error("flag not shown on pin");

  chk_master_clock: assert property (
    @(posedge clock) disable iff (!arst_n)
    (enable && isMaster) ##1 (enable && isMaster) |=> clkPinOut != $past(clkPinOut))
    else $error("master clock not toggling");

  chk_master_phase: assert property (
    @(posedge clock) disable iff (!arst_n)
    (enable && isMaster && !clkPinOut) |=> $stable(stateNow))
    else $error("master stepped on wrong phase");

  chk_bus_narrow: assert property (
    @(posedge clock) disable iff (!arst_n)
    (busWidth == PPI_BUS8) |=> (dataPinOe[31:8] == '0) && (dataPinOut[31:8] == '0))
    else $error("upper data lanes active in 8-bit mode");

  chk_fifo_full: assert property (
    @(posedge clock) disable iff (!arst_n)
    (core_reg.enabled && enable && entry.capture && !pushReady) |=> $stable(stateNow))
    else $error("capture taken with buffer full");

  chk_serial_byte: assert property (
    @(posedge clock) disable iff (!arst_n)
    (pushValid && busWidth == PPI_SERIAL) |-> (core_reg.serCount == PPI_SER_LAST))
    else $error("serial byte pushed early");

endmodule : ppi_top

`default_nettype wire

// file: sim/ppi_ext_model.sv
`timescale 1ns/10ps
`default_nettype none

// Far side of the parallel bus: drives every pin that the block has released
module ppi_ext_model
  import ppi_pkg::*;
(
  input  wire logic [PPI_CTRL_W-1:0] ctrlPinOut,
  input  wire logic [PPI_CTRL_W-1:0] ctrlPinOe,
  input  wire logic [PPI_DATA_W-1:0] dataPinOut,
  input  wire logic [PPI_DATA_W-1:0] dataPinOe,
  input  wire logic [PPI_CTRL_W-1:0] ctrlDrive,
  input  wire logic [PPI_DATA_W-1:0] dataDrive,
  output logic      [PPI_CTRL_W-1:0] ctrlPinIn,
  output logic      [PPI_DATA_W-1:0] dataPinIn
);
  // Buffer index and branch conditions sit on the released control pins
  assign ctrlPinIn = (ctrlPinOut & ctrlPinOe) | (ctrlDrive & ~ctrlPinOe);
  assign dataPinIn = (dataPinOut & dataPinOe) | (dataDrive & ~dataPinOe);
endmodule : ppi_ext_model

`default_nettype wire

// file: sim/tb_programmable_parallel_interface.sv
`timescale 1ns/10ps
`default_nettype none

module tb_programmable_parallel_interface;
  import ppi_pkg::*;

  logic                  clock      = 1'b0;
  logic                  arst_n     = 1'b0;
  logic                  enable     = 1'b0;
  logic                  isMaster   = 1'b0;
  logic                  allBuffers = 1'b1;
  logic                  wmWrite    = 1'b0;
  logic                  txValid    = 1'b0;
  logic                  rxReady    = 1'b0;
  logic [1:0]            busWidth   = PPI_BUS16;
  logic [PPI_WM_AW-1:0]  wmAddr     = 11'h000;
  logic [PPI_DATA_W-1:0] wmData     = 32'h0;
  logic [PPI_DATA_W-1:0] txData     = 32'h0;
  logic [PPI_DATA_W-1:0] dataDrive  = 32'hCAFE5A3C;
  logic [PPI_CTRL_W-1:0] ctrlDrive  = 16'h0000;
  logic [PPI_CTRL_W-1:0] ctrlPinIn;
  logic [PPI_CTRL_W-1:0] ctrlPinOut;
  logic [PPI_CTRL_W-1:0] ctrlPinOe;
  logic [PPI_DATA_W-1:0] dataPinIn;
  logic [PPI_DATA_W-1:0] dataPinOut;
  logic [PPI_DATA_W-1:0] dataPinOe;
  logic                  clkPinOut;
  logic                  clkPinOe;
  logic                  txReady;
  logic                  rxValid;
  logic [36:0]           rxData;
  logic [PPI_STATE_W-1:0] stateNow;
  int                    nErrors = 0;
  int                    nTests  = 0;

  // Four states: branch on control pin 0, capture loop, send with flags, hold with data enable
  logic [31:0] wave [32] = '{
    32'hFF00A500, 32'h00010001, 32'h00080201, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
    32'hFF003C00, 32'h00000000, 32'h00090101, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
    32'hFF005A00, 32'h00000000, 32'h00060303, 32'h00000F00, 32'h0, 32'h0, 32'h0, 32'h0,
    32'hFF00C300, 32'h00020002, 32'h00040300, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
  logic [31:0] oeTab   [4] = '{32'h000000FF, 32'h0000FFFF, 32'hFFFFFFFF, 32'h00000001};
  logic [15:0] ctrlTab [4] = '{16'hFF00, 16'hFF00, 16'h3F00, 16'hFF00};

  always #20 clock = ~clock;

  ppi_top ppi_top_i (
    .clock(clock), .arst_n(arst_n), .enable(enable), .isMaster(isMaster),
    .busWidth(busWidth), .allBuffers(allBuffers), .wmWrite(wmWrite), .wmAddr(wmAddr),
    .wmData(wmData), .ctrlPinIn(ctrlPinIn), .ctrlPinOut(ctrlPinOut), .ctrlPinOe(ctrlPinOe),
    .dataPinIn(dataPinIn), .dataPinOut(dataPinOut), .dataPinOe(dataPinOe),
    .clkPinOut(clkPinOut), .clkPinOe(clkPinOe), .txValid(txValid), .txData(txData),
    .txReady(txReady), .rxValid(rxValid), .rxReady(rxReady), .rxData(rxData),
    .stateNow(stateNow));

  ppi_ext_model ppi_ext_model_i (
    .ctrlPinOut(ctrlPinOut), .ctrlPinOe(ctrlPinOe), .dataPinOut(dataPinOut),
    .dataPinOe(dataPinOe), .ctrlDrive(ctrlDrive), .dataDrive(dataDrive),
    .ctrlPinIn(ctrlPinIn), .dataPinIn(dataPinIn));

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    nTests++;
    if (seen !== exp)
    begin
      nErrors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run();
    if (nErrors == 0 && nTests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run

  task automatic cycles(input int n);
    repeat (n) @(negedge clock);
  endtask : cycles

  task automatic test_reset();
    check(stateNow, 8'h00);
    check(ctrlPinOe, 16'h0000);
    check(dataPinOe, 32'h0);
    check(rxValid, 1'b0);
    check(clkPinOe, 1'b0);
  endtask : test_reset

  task automatic load_wave();
    for (int i = 0; i < 32; i++)
    begin
      wmWrite = 1'b1;
      wmAddr = 11'(i);
      wmData = wave[i];
      @(negedge clock);
    end
    wmWrite = 1'b0;
  endtask : load_wave

  // Capture until the FIFO refuses, then the sequencer must hold
  task automatic test_rx_fill();
    ctrlDrive = 16'h0013;
    cycles(4);
    enable = 1'b1;
    cycles(30);
    check(stateNow, 8'h01);
    check(rxValid, 1'b1);
    check(ctrlPinOut, 16'h3C00);
    check(ctrlPinOe, 16'hFF00);
    check(dataPinOe, 32'h0);
  endtask : test_rx_fill

  // Drain with the reader on rxReady stalling every other cycle
  task automatic test_rx_drain();
    enable = 1'b0;
    cycles(2);
    check(stateNow, 8'h00);
    check(ctrlPinOe, 16'h0000);
    for (int i = 0; i < 16; i++)
    begin
      check(rxValid, 1'b1);
      check(rxData, {5'h13, 32'h00005A3C});
      rxReady = i[0];
      @(negedge clock);
    end
    rxReady = 1'b0;
    check(rxValid, 1'b0);
  endtask : test_rx_drain

  task automatic send_word(input logic [31:0] d);
    txData = d;
    txValid = 1'b1;
    for (int i = 0; i < 10 && txReady !== 1'b1; i++)
      @(negedge clock);
    check(txReady, 1'b1);
    check(dataPinOut, {16'h0000, d[15:0]});
    check(ctrlPinOut, 16'h5400);
    check(stateNow, 8'h03);
    txValid = 1'b0;
  endtask : send_word

  task automatic test_tx();
    logic clkSeen;
    ctrlDrive = 16'h0000;
    cycles(2);
    enable = 1'b1;
    cycles(10);
    check(stateNow, 8'h02);
    check(txReady, 1'b0);
    send_word(32'h11223344);
    cycles(2);
    for (int w = 0; w < 4; w++)
    begin
      busWidth = 2'(w);
      cycles(2);
      check(dataPinOe, oeTab[w]);
      check(ctrlPinOe, ctrlTab[w]);
    end
    busWidth = PPI_BUS16;
    isMaster = 1'b1;
    cycles(2);
    check(clkPinOe, 1'b1);
    clkSeen = clkPinOut;
    @(negedge clock);
    check(clkPinOut, !clkSeen);
    @(negedge clock);
    check(clkPinOut, clkSeen);
    isMaster = 1'b0;
    cycles(2);
    check(clkPinOe, 1'b0);
    wmWrite = 1'b1;
    wmAddr = 11'h010;
    wmData = 32'h0;
    @(negedge clock);
    wmWrite = 1'b0;
    ctrlDrive = 16'h0002;
    cycles(6);
    ctrlDrive = 16'h0000;
    check(stateNow, 8'h02);
    send_word(32'hA1B2C3D4);
  endtask : test_tx

  // Serial capture packs eight samples of data pin 0 into one byte
  task automatic test_serial();
    enable = 1'b0;
    busWidth = PPI_SERIAL;
    allBuffers = 1'b0;
    ctrlDrive = 16'h0013;
    dataDrive = 32'h00000001;
    cycles(4);
    enable = 1'b1;
    cycles(30);
    check(stateNow, 8'h01);
    check(rxValid, 1'b1);
    check(rxData, {5'h03, 32'h000000FF});
    check(dataPinOe, 32'h0);
  endtask : test_serial

  initial
  begin
    repeat (8) @(negedge clock);
    test_reset();
    arst_n = 1'b1;
    load_wave();
    test_rx_fill();
    test_rx_drain();
    test_tx();
    test_serial();
    complete_run();
  end

  initial
  begin
    repeat (2000) @(posedge clock);
    nErrors++;
    complete_run();
  end
endmodule : tb_programmable_parallel_interface

`default_nettype wire
